/* File: design/dio_pkg.sv */
/*
  constants shared by the module-bus digital i/o block: register offsets,
  status bit positions, reset values and cycle counts.
  assumes a 50 mhz reference clock and a 32-bit classic wishbone register bus.
*/
package dio_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned CHANNELS = 32;
  localparam int unsigned GROUPS   = 4;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned ERR_W    = 8;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_TARGET     = 8'h00; // addressed module, 1..15
  localparam logic [7:0] OFS_DIRECTION  = 8'h04; // set_group_direction
  localparam logic [7:0] OFS_OUTPUTS    = 8'h08; // write_outputs
  localparam logic [7:0] OFS_CHANNELS   = 8'h0c; // read_channels
  localparam logic [7:0] OFS_WRITE_READ = 8'h10; // write_and_read_channels
  localparam logic [7:0] OFS_OUT_STATUS = 8'h14; // write_outputs_with_status
  localparam logic [7:0] OFS_STATUS     = 8'h18; // error status word
  localparam logic [7:0] OFS_INIT       = 8'h1c; // module_initialize
  localparam logic [7:0] OFS_WD_CONFIG  = 8'h20; // watchdog_configure
  localparam logic [7:0] OFS_WD_RELOAD  = 8'h24; // watchdog_reload

  // ************************************************************
  // status word bit positions
  // ************************************************************
  localparam int unsigned ST_PARITY   = 0;
  localparam int unsigned ST_OVERRUN  = 1;
  localparam int unsigned ST_TIMEOUT  = 2;
  localparam int unsigned ST_WATCHDOG = 3;
  localparam int unsigned ST_HEAT_LO  = 6;
  localparam int unsigned ST_HEAT_HI  = 7;

  // watchdog config fields
  localparam int unsigned WD_EN_BIT = 31;
  localparam int unsigned WD_MS_W   = 17; // 0..131071 ms

  // ************************************************************
  // reset values and answers
  // ************************************************************
  localparam logic [31:0]        UNREACHABLE  = 32'hffffffff; // -1
  localparam logic [GROUPS-1:0]  DIR_RESET    = 4'h0;
  localparam logic [WD_MS_W-1:0] WD_START_MS  = 17'h0000a;     // 10 ms
  localparam logic [ADDR_W-1:0]  SHARED_ADDR  = 4'h1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned FILTER_NS   = 12000;
  localparam int unsigned FILTER_CYC  = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WD_TICK_MS  = 1;
  localparam int unsigned MS_CYC      = WD_TICK_MS * CLK_MHZ * 1000;
  localparam int unsigned FILT_CNT_W  = 10;

endpackage

/* File: design/module_bus_digital_io.sv */
/*
  32-channel digital i/o module reached as a wishbone slave: group direction,
  output latch, filtered read-back, sticky error status and a link watchdog.
  assumes channel pins, overheat flags and the address strap are asynchronous
  and that transfer error events come from logic on ref_clk_i.
*/
// Contract
// - each of four direction bits sets eight channels; 0 input, 1 output.
// - direction word bits 31 to 4 have no effect.
// - module initialize makes all channels inputs until direction is rewritten.
// - output word bit n drives channel n+1; 0 low, 1 high.
// - output bits for input channels are ignored.
// - channel read returns sensed level of every channel, bit n is channel n+1.
// - each channel level passes a filter of about twelve microseconds.
// - status bits 0,1,2 report parity, overrun and timeout errors.
// - watchdog expiry sets status bit 3 and switches off all drivers.
// - overheat sets bit 6 or 7 and disables that bank's driver.
// - status 0 means ok, positive the error bits, -1 unreachable.
// - a module answers only commands with its own address, 1 to 15; combined write-read is taken by a module strapped to 1 whatever the target.
// - combined write-read reloads the watchdog and leaves it enabled.
// - an output write variant also returns the error status word.
// - enabled watchdog counts down; at zero module stops, outputs reset.
// - at power-up the watchdog starts enabled with ten milliseconds.
// - module initialize clears latched overheat and timeout errors.
`timescale 1ns/1ps

module module_bus_digital_io #(
  parameter int unsigned MS_CYCLES = dio_pkg::MS_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  module_addr_i,
  input  wire logic [31:0] chan_in_i,
  output logic      [31:0] chan_out_o,
  output logic      [31:0] chan_oe_n_o,
  input  wire logic        low_bank_overheat_i,
  input  wire logic        high_bank_overheat_i,
  input  wire logic        parity_err_i,
  input  wire logic        overrun_err_i,
  input  wire logic        timeout_err_i
);

  // ************************************************************
  // declarations
  // ************************************************************
  localparam int unsigned PINS = dio_pkg::CHANNELS + 2 + dio_pkg::ADDR_W;

  logic [PINS-1:0]                 pin_meta_ff;
  logic [PINS-1:0]                 pin_sync_ff;
  logic [31:0]                     chan_sync;
  logic                            heat_lo_sync;
  logic                            heat_hi_sync;
  logic [dio_pkg::ADDR_W-1:0]      own_addr;

  logic [31:0]                     filt_lvl_ff;
  logic [dio_pkg::ADDR_W-1:0]      target_ff;
  logic [dio_pkg::GROUPS-1:0]      dir_ff;
  logic [31:0]                     out_ff;
  logic [31:0]                     oe_n_ff;
  logic [dio_pkg::ERR_W-1:0]       err_ff;
  logic [dio_pkg::ERR_W-1:0]       snap_err_ff;
  logic                            wd_en_ff;
  logic [dio_pkg::WD_MS_W-1:0]     wd_start_ff;
  logic [dio_pkg::WD_MS_W-1:0]     wd_cnt_ff;
  logic [31:0]                     wd_pre_ff;
  logic                            ack_ff;
  logic [31:0]                     rdat_ff;

  logic                            req;
  logic                            wr;
  logic [31:0]                     byte_mask;
  logic                            addressed;
  logic                            shared_ok;
  logic                            cmd_dir;
  logic                            cmd_out;
  logic                            cmd_wr_rd;
  logic                            cmd_out_st;
  logic                            cmd_init;
  logic                            cmd_wd_cfg;
  logic                            cmd_wd_rld;
  logic                            wd_tick;
  logic                            wd_fire;
  logic [31:0]                     dir_mask;
  logic [31:0]                     out_mask;
  logic [dio_pkg::ERR_W-1:0]       err_set;
  logic [dio_pkg::ERR_W-1:0]       err_clr;
  logic [31:0]                     status_word;
  logic [31:0]                     nxt_rdat;

  // ************************************************************
  // pin synchronisers
  // ************************************************************

  // two flops for every asynchronous input
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else if (ce_i) begin
      pin_meta_ff <= {module_addr_i, high_bank_overheat_i, low_bank_overheat_i, chan_in_i};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign chan_sync    = pin_sync_ff[31:0];
  assign heat_lo_sync = pin_sync_ff[32];
  assign heat_hi_sync = pin_sync_ff[33];
  assign own_addr     = pin_sync_ff[PINS-1:34];

  // ************************************************************
  // input filter, one per channel
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < dio_pkg::CHANNELS; gi++) begin : g_filt
      logic [dio_pkg::FILT_CNT_W-1:0] cnt_ff;

      // level must differ for the whole filter time before it is taken
      always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          cnt_ff         <= '0;
          filt_lvl_ff[gi] <= 1'b0;
        end else if (ce_i) begin
          if (chan_sync[gi] == filt_lvl_ff[gi]) begin
            cnt_ff <= '0;
          end else if (cnt_ff == dio_pkg::FILT_CNT_W'(dio_pkg::FILTER_CYC - 1)) begin
            cnt_ff          <= '0;
            filt_lvl_ff[gi] <= chan_sync[gi];
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      end

      // each direction bit covers eight channels
      assign dir_mask[gi] = dir_ff[gi / 8];
    end
  endgenerate

  // ************************************************************
  // bus decode
  // ************************************************************

  // a request is taken once; ack closes it
  assign req       = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr        = req && wb_we_i;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // commands only reach this module when its strap matches; combined write-read needs only a strap of 1
  assign addressed = (own_addr != '0) && (target_ff == own_addr);
  assign shared_ok = (own_addr == dio_pkg::SHARED_ADDR);

  // one decoded strobe per command word
  assign cmd_dir    = wr && addressed && (wb_adr_i == dio_pkg::OFS_DIRECTION);
  assign cmd_out    = wr && addressed && (wb_adr_i == dio_pkg::OFS_OUTPUTS);
  assign cmd_wr_rd  = wr && shared_ok && (wb_adr_i == dio_pkg::OFS_WRITE_READ);
  assign cmd_out_st = wr && addressed && (wb_adr_i == dio_pkg::OFS_OUT_STATUS);
  assign cmd_init   = wr && addressed && (wb_adr_i == dio_pkg::OFS_INIT);
  assign cmd_wd_cfg = wr && addressed && (wb_adr_i == dio_pkg::OFS_WD_CONFIG);
  assign cmd_wd_rld = wr && addressed && (wb_adr_i == dio_pkg::OFS_WD_RELOAD);

  // target module register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      target_ff <= '0;
    end else if (ce_i && wr && wb_sel_i[0] && (wb_adr_i == dio_pkg::OFS_TARGET)) begin
      target_ff <= wb_dat_i[dio_pkg::ADDR_W-1:0];
    end
  end

  // ************************************************************
  // direction and output latch
  // ************************************************************

  // only the four low bits steer direction
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dir_ff <= dio_pkg::DIR_RESET;
    end else if (ce_i) begin
      if (cmd_init) begin
        dir_ff <= dio_pkg::DIR_RESET;
      end else if (cmd_dir && wb_sel_i[0]) begin
        dir_ff <= wb_dat_i[dio_pkg::GROUPS-1:0];
      end
    end
  end

  // output write touches only bits of output groups
  assign out_mask = dir_mask & byte_mask;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      out_ff <= '0;
    end else if (ce_i) begin
      if (wd_fire || err_ff[dio_pkg::ST_WATCHDOG]) begin
        out_ff <= '0;
      end else if (cmd_out || cmd_wr_rd || cmd_out_st) begin
        out_ff <= (out_ff & ~out_mask) | (wb_dat_i & out_mask);
      end
    end
  end

  // driver enables: direction, watchdog and bank overheat
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      oe_n_ff <= '1;
    end else if (ce_i) begin
      oe_n_ff <= ~(dir_mask
                   & {32{!err_ff[dio_pkg::ST_WATCHDOG]}}
                   & {{16{!err_ff[dio_pkg::ST_HEAT_HI]}},
                      {16{!err_ff[dio_pkg::ST_HEAT_LO]}}});
    end
  end

  assign chan_out_o  = out_ff;
  assign chan_oe_n_o = oe_n_ff;

  // ************************************************************
  // watchdog
  // ************************************************************

  // millisecond prescaler feeding the countdown
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wd_pre_ff <= '0;
    end else if (ce_i) begin
      if (wd_tick) begin
        wd_pre_ff <= '0;
      end else begin
        wd_pre_ff <= wd_pre_ff + 1'b1;
      end
    end
  end

  assign wd_tick = (wd_pre_ff == 32'(MS_CYCLES - 1));
  assign wd_fire = wd_en_ff && !err_ff[dio_pkg::ST_WATCHDOG] && (wd_cnt_ff == '0);

  // enable, start value and counter
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wd_en_ff    <= 1'b1;
      wd_start_ff <= dio_pkg::WD_START_MS;
      wd_cnt_ff   <= dio_pkg::WD_START_MS;
    end else if (ce_i) begin
      if (cmd_wd_cfg) begin
        wd_en_ff    <= wb_dat_i[dio_pkg::WD_EN_BIT];
        wd_start_ff <= wb_dat_i[dio_pkg::WD_MS_W-1:0];
        wd_cnt_ff   <= wb_dat_i[dio_pkg::WD_MS_W-1:0];
      end else if (cmd_wr_rd) begin
        wd_en_ff  <= 1'b1;
        wd_cnt_ff <= wd_start_ff;
      end else if (cmd_wd_rld) begin
        wd_cnt_ff <= wd_start_ff;
      end else if (wd_en_ff && wd_tick && (wd_cnt_ff != '0)) begin
        wd_cnt_ff <= wd_cnt_ff - 1'b1;
      end
    end
  end

  // ************************************************************
  // error status
  // ************************************************************

  // hardware events, sticky until module initialize
  always_comb begin
    err_set                       = '0;
    err_set[dio_pkg::ST_PARITY]   = parity_err_i;
    err_set[dio_pkg::ST_OVERRUN]  = overrun_err_i;
    err_set[dio_pkg::ST_TIMEOUT]  = timeout_err_i;
    err_set[dio_pkg::ST_WATCHDOG] = wd_fire;
    err_set[dio_pkg::ST_HEAT_LO]  = heat_lo_sync;
    err_set[dio_pkg::ST_HEAT_HI]  = heat_hi_sync;
  end

  assign err_clr = cmd_init ? '1 : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      err_ff <= '0;
    end else if (ce_i) begin
      err_ff <= (err_ff & ~err_clr) | err_set;
    end
  end

  assign status_word = {24'h000000, err_ff};

  // status snapshot taken with the output write with status
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      snap_err_ff <= '0;
    end else if (ce_i && cmd_out_st) begin
      snap_err_ff <= err_ff;
    end
  end

  // ************************************************************
  // read mux and acknowledge
  // ************************************************************

  // unreachable module answers all ones on command words, but zero on module initialize
  always_comb begin
    nxt_rdat = 32'h00000000;
    unique case (wb_adr_i)
      dio_pkg::OFS_TARGET:     nxt_rdat = {28'h0000000, target_ff};
      dio_pkg::OFS_DIRECTION:  nxt_rdat = addressed ? {28'h0000000, dir_ff} : dio_pkg::UNREACHABLE;
      dio_pkg::OFS_OUTPUTS:    nxt_rdat = addressed ? out_ff : dio_pkg::UNREACHABLE;
      dio_pkg::OFS_CHANNELS:   nxt_rdat = addressed ? filt_lvl_ff : dio_pkg::UNREACHABLE;
      dio_pkg::OFS_WRITE_READ: nxt_rdat = shared_ok ? filt_lvl_ff : dio_pkg::UNREACHABLE;
      dio_pkg::OFS_OUT_STATUS: nxt_rdat = addressed ? {24'h000000, snap_err_ff}
                                                    : dio_pkg::UNREACHABLE;
      dio_pkg::OFS_STATUS:     nxt_rdat = addressed ? status_word : dio_pkg::UNREACHABLE;
      dio_pkg::OFS_WD_CONFIG:  nxt_rdat = addressed ? {wd_en_ff, 14'h0000, wd_start_ff}
                                                    : dio_pkg::UNREACHABLE;
      dio_pkg::OFS_WD_RELOAD:  nxt_rdat = addressed ? {15'h0000, wd_cnt_ff}
                                                    : dio_pkg::UNREACHABLE;
      default:                 nxt_rdat = 32'h00000000;
    endcase
  end

  // one wait-free cycle: ack and data the edge after the request
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else if (ce_i) begin
      ack_ff <= req;
      if (req && !wb_we_i) begin
        rdat_ff <= nxt_rdat;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule

/* File: tb/channel_pads.sv */
/*
  field side of the 32 channel pins: a driven pin shows the block's level,
  a released pin shows the level of the external source.
  assumes driver enable is low while the block drives the pin.
*/
`timescale 1ns/1ps

module channel_pads (
  input  wire logic [31:0] drive_i,
  input  wire logic [31:0] oe_n_i,
  input  wire logic [31:0] field_i,
  output logic      [31:0] sense_o
);
  // per pin resolution of block driver against field source
  assign sense_o = (~oe_n_i & drive_i) | (oe_n_i & field_i);
endmodule

/* File: tb/dio_checker.sv */
/*
  concurrent checks on the ports of the module-bus digital i/o block.
  assumes one clock domain and a bind from the bench top file.
*/
`timescale 1ns/1ps

module dio_checker (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [31:0] chan_out_o,
  input wire logic [31:0] chan_oe_n_o,
  input wire logic        low_bank_overheat_i,
  input wire logic        high_bank_overheat_i
);
  logic       taken;
  logic [3:0] tgt_ff;

  // request accepted at this edge
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;

  // shadow of the target register
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) tgt_ff <= 4'h0;
    else if (taken && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]) tgt_ff <= wb_dat_i[3:0];
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_ack_one_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_take: assert property (taken |=> wb_ack_o)
    else $error("accepted request not answered");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_drivers_off: assert property ($rose(rstn_i) |-> &chan_oe_n_o && chan_out_o == 32'h0)
    else $error("drivers not off after reset");
  a_low_heat_off: assert property (low_bank_overheat_i [*3] |-> ##[0:3] (&chan_oe_n_o[15:0]))
    else $error("low bank driver still on while overheated");
  a_high_heat_off: assert property (high_bank_overheat_i [*3] |-> ##[0:3] (&chan_oe_n_o[31:16]))
    else $error("high bank driver still on while overheated");
  a_unmapped_zero: assert property (taken && !wb_we_i && wb_adr_i > 8'h24 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_target_read: assert property (taken && !wb_we_i && wb_adr_i == 8'h00 |=> wb_dat_o == {28'h0, tgt_ff})
    else $error("target read mismatch");
  a_dat_on_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data changed without ack");
endmodule

/* File: tb/module_bus_digital_io_test.sv */
/*
  self-checking bench for the module-bus digital i/o block: wishbone tasks
  and a directed sequence. assumes the checker and pad model files compile first.
*/
`timescale 1ns/1ps

bind module_bus_digital_io dio_checker dio_checker_i (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .chan_out_o(chan_out_o), .chan_oe_n_o(chan_oe_n_o),
  .low_bank_overheat_i(low_bank_overheat_i), .high_bank_overheat_i(high_bank_overheat_i));

module module_bus_digital_io_test;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, strap = 4'h3;
  logic [31:0] wdat = 32'h0, rdat, q, field = 32'ha5a5a5a5, sense, cout, oe_n;
  logic ack, heat_lo = 1'b0, heat_hi = 1'b0;
  logic [2:0] ev = 3'h0;
  int mismatches = 0, checks_done = 0;

  // 50 mhz reference clock
  always #10 clk = ~clk;

  module_bus_digital_io #(.MS_CYCLES(10)) module_bus_digital_io_i (
    .ref_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .module_addr_i(strap), .chan_in_i(sense), .chan_out_o(cout),
    .chan_oe_n_o(oe_n), .low_bank_overheat_i(heat_lo), .high_bank_overheat_i(heat_hi),
    .parity_err_i(ev[0]), .overrun_err_i(ev[1]), .timeout_err_i(ev[2]));

  channel_pads channel_pads_i (.drive_i(cout), .oe_n_i(oe_n), .field_i(field), .sense_o(sense));

  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      mismatches++;
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(q, exp, what);
  endtask

  // directed sequence
  initial begin
    idle(16);
    rstn <= 1'b1;
    idle(3);
    bus(1'b1, 8'h00, 32'h3); // address own module
    rd(8'h00, 32'h3, "target readback");
    bus(1'b1, 8'h20, 32'h0); // watchdog off
    rd(8'h18, 32'h0, "status after reset");
    rd(8'h10, 32'hffffffff, "combined refused");
    rd(8'h40, 32'h0, "unmapped read");
    bus(1'b1, 8'h04, 32'hfffffff5);
    idle(2);
    check(oe_n, 32'hff00ff00, "group direction");
    bus(1'b1, 8'h08, 32'hffffffff);
    bus(1'b1, 8'h04, 32'hf);
    idle(2);
    check(cout, 32'h00ff00ff, "input bits ignored");
    bus(1'b1, 8'h04, 32'h5);
    bus(1'b1, 8'h08, 32'h12345678);
    idle(2);
    check(cout, 32'h00340078, "output bit map");
    rd(8'h08, 32'h00340078, "output latch");
    idle(620);
    rd(8'h0c, 32'ha534a578, "read back");
    field <= 32'h5a5a5a5a;
    idle(20);
    rd(8'h0c, 32'ha534a578, "filter still old");
    idle(620);
    rd(8'h0c, 32'h5a345a78, "filter settled");
    for (int i = 0; i < 3; i++) begin
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      idle(2);
      rd(8'h18, 32'h7 >> (2 - i), "transfer error");
    end
    bus(1'b1, 8'h14, 32'h0);
    rd(8'h14, 32'h7, "status with write");
    heat_lo <= 1'b1;
    idle(6);
    heat_lo <= 1'b0;
    idle(2);
    check(oe_n, 32'hff00ffff, "low bank off");
    heat_hi <= 1'b1;
    idle(6);
    heat_hi <= 1'b0;
    rd(8'h18, 32'hc7, "heat latched");
    bus(1'b1, 8'h00, 32'h5);
    rd(8'h18, 32'hffffffff, "other address");
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h1c, 32'h0);
    rd(8'h18, 32'h0, "init clears");
    rd(8'h04, 32'h0, "init inputs");
    bus(1'b1, 8'h04, 32'h1);
    idle(2);
    check(oe_n, 32'hffffff00, "driver back on");
    strap <= 4'h1;
    idle(4);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h20, 32'h80000005); // five ms start, enabled
    bus(1'b1, 8'h04, 32'hf);
    repeat (6) begin
      bus(1'b1, 8'h10, 32'hc3c3c3c3); // lone module at address 1
      idle(30);
    end
    bus(1'b1, 8'h24, 32'h0); // plain reload keeps it alive too
    rd(8'h18, 32'h0, "reload keeps alive");
    rd(8'h20, 32'h80000005, "watchdog setting");
    check(cout, 32'hc3c3c3c3, "combined write");
    idle(70);
    rd(8'h18, 32'h8, "watchdog expired");
    check(oe_n, 32'hffffffff, "drivers off");
    check(cout, 32'h0, "outputs reset");
    rstn <= 1'b0;
    idle(16);
    rstn <= 1'b1;
    idle(3);
    bus(1'b1, 8'h00, 32'h1);
    ce <= 1'b0;
    idle(40); // low clock enable holds the countdown
    ce <= 1'b1;
    idle(80);
    rd(8'h18, 32'h0, "power-up count running");
    idle(30);
    rd(8'h18, 32'h8, "power-up watchdog");
    tally_and_finish();
  end
endmodule
